/* hdl/fp_cmp_classify.sv */
// compare outcome and invalid flag for the compare path
`timescale 1ns/1ns
`default_nettype none
`include "fp_status_map.svh"
module fp_cmp_classify
   import fp_status_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       a_nan,
   input  wire logic       b_nan,
   input  wire logic       a_snan,
   input  wire logic       b_snan,
   input  wire logic       signal_qnan,
   input  wire logic       lt,
   input  wire logic       eq,
   output var  logic [1:0] cc_reg,
   output var  logic       invalid_reg
);
   typedef struct packed {
      logic [1:0] cc;
      logic       inv;
   } st_t;
   st_t s_reg;
   st_t s_next;
   always_comb begin
      s_next = s_reg;
      if (a_nan || b_nan) begin
         s_next.cc = `FCC_UN;
      end else if (eq) begin
         s_next.cc = `FCC_EQ;
      end else if (lt) begin
         s_next.cc = `FCC_LT;
      end else begin
         s_next.cc = `FCC_GT;
      end
      // signaling compare also faults on quiet nan
      s_next.inv = a_snan || b_snan || (signal_qnan && (a_nan || b_nan));
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign cc_reg      = s_reg.cc;
   assign invalid_reg = s_reg.inv;
endmodule
`default_nettype wire

/* hdl/fp_status_map.svh */
// register layout and codes of the floating-point status register
`ifndef FP_STATUS_MAP_SVH
`define FP_STATUS_MAP_SVH
`define RD_HI        31
`define RD_LO        30
`define TEM_HI       27
`define TEM_LO       23
`define NS_BIT       22
`define VER_HI       19
`define VER_LO       17
`define FTT_HI       16
`define FTT_LO       14
`define FCC_HI       11
`define FCC_LO       10
`define AEXC_HI      9
`define AEXC_LO      5
`define CEXC_HI      4
`define CEXC_LO      0
`define FTT_NONE     3'h0
`define FTT_IEEE     3'h1
`define FTT_SEQ      3'h4
`define FCC_EQ       2'h0
`define FCC_LT       2'h1
`define FCC_GT       2'h2
`define FCC_UN       2'h3
`define EXC_NX       0
`define EXC_DZ       1
`define EXC_UF       2
`define EXC_OF       3
`define EXC_NV       4
`define RD_NEAREST   2'h0
`define RD_ZERO      2'h1
`define RD_POS       2'h2
`define RD_NEG       2'h3
`define FIELD_ZERO5  5'h00
`define FIELD_ZERO2  2'h0
`define FIELD_ZERO3  3'h0
`endif

/* hdl/fp_status_pkg.sv */
// types of the floating-point status block
package fp_status_pkg;
   typedef logic [4:0] exc_t;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_ARITH,
      OP_COMPARE
   } op_kind_t;
endpackage

/* hdl/fp_status_trap_logic.sv */
// floating-point status register, exception accumulation and trap generation
// How it works
// - round_dir field selects rounding direction
// - five trap enables gate exception traps
// - nonstandard flag always reads zero
// - trap kind held until store or operate
// - trap kind 0 none, 1 ieee, 4 sequence
// - issue while unit busy gives sequence error
// - queue store with empty queue gives sequence error
// - compares and status load write cond code, 0/1/2/3
// - cond branch decides from cond code only
// - any nan operand makes compare unordered
// - trapping compare leaves cond code unchanged
// - mask and current decide trap or accrue
// - accrued bits 9..5, current bits 4..0
// - each operate rewrites current exceptions fully
// - status load and store without privilege check
// - improper operand flags invalid exception
// - masked underflow also sets inexact
`timescale 1ns/1ns
`default_nettype none
`include "fp_status_map.svh"
module fp_status_trap_logic
   import fp_status_pkg::*;
#(
   parameter logic [2:0] VERSION = 3'h0 // arbitrary version value
)(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        op_valid,
   input  wire logic        op_is_compare,
   input  wire logic [4:0]  op_exc,
   input  wire logic        cmp_a_nan,
   input  wire logic        cmp_b_nan,
   input  wire logic        cmp_a_snan,
   input  wire logic        cmp_b_snan,
   input  wire logic        cmp_signal,
   input  wire logic        cmp_lt,
   input  wire logic        cmp_eq,
   input  wire logic        unit_busy,
   input  wire logic        queue_not_empty,
   input  wire logic        store_queue,
   input  wire logic        load_status,
   input  wire logic [31:0] load_data,
   input  wire logic        store_status,
   input  wire logic        branch_valid,
   input  wire logic [3:0]  branch_cond,
   output var  logic [31:0] status_data,
   output var  logic        status_data_valid,
   output var  logic [1:0]  round_dir,
   output var  logic        fp_exception,
   output var  logic        branch_taken,
   output var  logic        branch_done
);
   typedef struct packed {
      logic [1:0]  rd;
      exc_t        tem;
      logic [2:0]  ftt;
      logic [1:0]  fcc;
      exc_t        aexc;
      exc_t        cexc;
      logic        cmp_pend;
      logic        cmp_trap;
      logic [31:0] rdata;
      logic        rvalid;
      logic        trap;
      logic        btaken;
      logic        bdone;
   } st_t;
   st_t s_reg;
   st_t s_next;
   logic [1:0] cmp_cc;
   logic       cmp_inv;
   logic [31:0] image;
   exc_t       new_exc;
   logic       fcc_match;
   // compare result lands one cycle after issue
   fp_cmp_classify u_cmp (
      .clk         (clk),
      .srst        (srst),
      .a_nan       (cmp_a_nan),
      .b_nan       (cmp_b_nan),
      .a_snan      (cmp_a_snan),
      .b_snan      (cmp_b_snan),
      .signal_qnan (cmp_signal),
      .lt          (cmp_lt),
      .eq          (cmp_eq),
      .cc_reg      (cmp_cc),
      .invalid_reg (cmp_inv)
   );
   always_comb begin
      image = '0;
      image[`RD_HI:`RD_LO]     = s_reg.rd;
      image[`TEM_HI:`TEM_LO]   = s_reg.tem;
      image[`NS_BIT]           = 1'b0;
      image[`VER_HI:`VER_LO]   = VERSION;
      image[`FTT_HI:`FTT_LO]   = s_reg.ftt;
      image[`FCC_HI:`FCC_LO]   = s_reg.fcc;
      image[`AEXC_HI:`AEXC_LO] = s_reg.aexc;
      image[`CEXC_HI:`CEXC_LO] = s_reg.cexc;
   end
   // branch conditions: 1..4 match fcc 0..3, 5 = not equal, 6 = ordered, 8 = always, 0 = never
   always_comb begin
      case (branch_cond)
         4'h0: fcc_match = 1'b0;
         4'h8: fcc_match = 1'b1;
         4'h1: fcc_match = (s_reg.fcc == `FCC_EQ);
         4'h2: fcc_match = (s_reg.fcc == `FCC_LT);
         4'h3: fcc_match = (s_reg.fcc == `FCC_GT);
         4'h4: fcc_match = (s_reg.fcc == `FCC_UN);
         4'h5: fcc_match = (s_reg.fcc != `FCC_EQ);
         4'h6: fcc_match = (s_reg.fcc != `FCC_UN);
         default: fcc_match = 1'b0;
      endcase
   end
   always_comb begin
      s_next = s_reg;
      new_exc = op_exc;
      s_next.rvalid = 1'b0;
      s_next.trap = 1'b0;
      s_next.bdone = branch_valid;
      s_next.btaken = branch_valid && fcc_match;
      if (op_exc[`EXC_UF] && !s_reg.tem[`EXC_UF]) begin
         new_exc[`EXC_NX] = 1'b1;
      end
      // compare: invalid known one cycle late, fcc held back until then
      s_next.cmp_pend = 1'b0;
      if (s_reg.cmp_pend) begin
         if (s_reg.tem[`EXC_NV] && cmp_inv) begin
            s_next.cexc = s_reg.cexc | (5'h01 << `EXC_NV);
            s_next.ftt = `FTT_IEEE;
            s_next.trap = 1'b1;
         end else begin
            s_next.fcc = cmp_cc;
            if (cmp_inv) begin
               s_next.cexc = s_reg.cexc | (5'h01 << `EXC_NV);
               s_next.aexc = s_reg.aexc | (5'h01 << `EXC_NV);
            end
         end
      end
      if (store_queue && !queue_not_empty) begin
         s_next.ftt = `FTT_SEQ;
         s_next.trap = 1'b1;
      end else if (op_valid && unit_busy) begin
         s_next.ftt = `FTT_SEQ;
         s_next.trap = 1'b1;
      end else if (op_valid) begin
         s_next.cexc = new_exc;
         // a compare trap landing this cycle keeps its trap kind
         if (!s_next.trap) begin
            s_next.ftt = `FTT_NONE;
         end
         if (op_is_compare) begin
            s_next.cmp_pend = 1'b1;
            s_next.cexc = new_exc & ~(5'h01 << `EXC_NV);
         end else if ((s_reg.tem & new_exc) != `FIELD_ZERO5) begin
            s_next.ftt = `FTT_IEEE;
            s_next.trap = 1'b1;
         end else begin
            s_next.aexc = s_reg.aexc | new_exc;
         end
      end
      // status transfers, no privilege checked
      if (store_status) begin
         s_next.rdata = image;
         s_next.rvalid = 1'b1;
         if (!s_next.trap) begin
            s_next.ftt = `FTT_NONE;
         end
      end
      if (load_status) begin
         s_next.rd = load_data[`RD_HI:`RD_LO];
         s_next.tem = load_data[`TEM_HI:`TEM_LO];
         s_next.fcc = load_data[`FCC_HI:`FCC_LO];
         s_next.aexc = load_data[`AEXC_HI:`AEXC_LO];
         s_next.cexc = load_data[`CEXC_HI:`CEXC_LO];
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   always_comb begin
      status_data       = s_reg.rdata;
      status_data_valid = s_reg.rvalid;
      round_dir         = s_reg.rd;
      fp_exception      = s_reg.trap;
      branch_taken      = s_reg.btaken;
      branch_done       = s_reg.bdone;
   end
endmodule
`default_nettype wire

/* sim/fp_status_trap_logic_chk.sv */
// port assertions for the floating-point status block
`timescale 1ns/1ns
`default_nettype none
module fp_status_chk (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        op_valid,
   input wire logic        unit_busy,
   input wire logic        store_queue,
   input wire logic        queue_not_empty,
   input wire logic        load_status,
   input wire logic [31:0] load_data,
   input wire logic        store_status,
   input wire logic [31:0] status_data,
   input wire logic        status_data_valid,
   input wire logic [1:0]  round_dir,
   input wire logic        fp_exception,
   input wire logic        branch_valid,
   input wire logic        branch_done
);
   logic [1:0] rd_q;
   always_ff @(posedge clk) begin
      rd_q <= load_data[31:30];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_trap;
      ##1 fp_exception;
   endsequence
   AST_READ: assert property (store_status |=> status_data_valid)
      else $error("no status answer");
   AST_NS: assert property (status_data_valid |-> !status_data[22])
      else $error("nonstandard bit set");
   AST_FTT: assert property (status_data_valid |-> status_data[16:14] inside {3'h0, 3'h1, 3'h4})
      else $error("reserved trap kind");
   AST_RD: assert property (load_status |=> round_dir == rd_q)
      else $error("rounding field not loaded");
   AST_SEQ: assert property (op_valid && unit_busy |-> s_trap)
      else $error("busy issue not trapped");
   AST_QUEUE: assert property (store_queue && !queue_not_empty |-> s_trap)
      else $error("empty queue store not trapped");
   AST_QUIET: assert property (!op_valid && !store_queue && !$past(op_valid) |=> !fp_exception)
      else $error("trap without cause");
   AST_BR: assert property (branch_valid |=> branch_done)
      else $error("branch not answered");
   AST_BR_ONLY: assert property (!branch_valid |=> !branch_done)
      else $error("branch answer without request");
   AST_HOLD: assert property (!store_status |=> $stable(status_data))
      else $error("status image changed without store");
endmodule
bind fp_status_trap_logic fp_status_chk fp_status_chk_i (.*);
`default_nettype wire

/* sim/iu_model.sv */
// integer-unit side model issuing operations and status transfers
`timescale 1ns/1ns
`default_nettype none
module iu_model (
   input  wire logic        clk,
   output var  logic        op_valid,
   output var  logic        op_is_compare,
   output var  logic [4:0]  op_exc,
   output var  logic [6:0]  cmp,
   output var  logic        unit_busy,
   output var  logic        queue_not_empty,
   output var  logic        store_queue,
   output var  logic        load_status,
   output var  logic [31:0] load_data,
   output var  logic        store_status,
   output var  logic        branch_valid,
   output var  logic [3:0]  branch_cond
);
   initial begin
      {op_valid, op_is_compare, op_exc, cmp, unit_busy, queue_not_empty} = '0;
      {store_queue, load_status, load_data, store_status, branch_valid, branch_cond} = '0;
   end
   // released strobes go low and their data inverted, except op_is_compare and queue_not_empty which hold, so stale values cannot pass
   task op(input logic busy, input logic c, input logic [4:0] e, input logic [6:0] k);
      @(posedge clk);
      {op_valid, unit_busy, op_is_compare, op_exc, cmp} <= {1'b1, busy, c, e, k};
      @(posedge clk);
      {op_valid, unit_busy, op_exc, cmp} <= {1'b0, 1'b0, ~e, ~k};
      #1;
   endtask
   task load(input logic [31:0] d);
      @(posedge clk);
      {load_status, load_data} <= {1'b1, d};
      @(posedge clk);
      {load_status, load_data} <= {1'b0, ~d};
      #1;
   endtask
   task cmd(input logic st, input logic sq, input logic qne, input logic bv, input logic [3:0] bc);
      @(posedge clk);
      {store_status, store_queue, queue_not_empty, branch_valid, branch_cond} <= {st, sq, qne, bv, bc};
      @(posedge clk);
      {store_status, store_queue, branch_valid, branch_cond} <= {3'h0, ~bc};
      #1;
   endtask
endmodule
`default_nettype wire

/* sim/test_fp_status_trap_logic.sv */
// self-checking testbench of the floating-point status block
`timescale 1ns/1ns
`default_nettype none
module test_fp_status_trap_logic;
   logic clk, srst, op_valid, op_is_compare, unit_busy, queue_not_empty, store_queue;
   logic load_status, store_status, branch_valid, status_data_valid, fp_exception;
   logic branch_taken, branch_done;
   logic [4:0] op_exc;
   logic [6:0] cmp;
   logic [3:0] branch_cond;
   logic [1:0] round_dir;
   logic [31:0] load_data, status_data;
   int miscompares = 0;
   int checks = 0;
   localparam logic [4:0] EX[3] = '{5'h01, 5'h08, 5'h04};
   localparam logic [9:0] IMG[3] = '{10'h021, 10'h128, 10'h1A5};
   localparam logic [6:0] CV[5] = '{7'h01, 7'h02, 7'h00, 7'h40, 7'h24};
   localparam logic [1:0] FC[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
   iu_model iu_model_i (.*);
   fp_status_trap_logic fp_status_trap_logic_i (.*, .cmp_a_nan(cmp[6]), .cmp_b_nan(cmp[5]),
      .cmp_a_snan(cmp[4]), .cmp_b_snan(cmp[3]), .cmp_signal(cmp[2]), .cmp_lt(cmp[1]),
      .cmp_eq(cmp[0]));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rd(input logic [31:0] exp);
      iu_model_i.cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
      chk(status_data, exp);
      chk(32'(status_data_valid), 32'h1);
   endtask
   task t_round;
      logic [31:0] d;
      for (int i = 0; i < 4; i++) begin
         d = {i[1:0], 30'h3FFF_FFFF};
         iu_model_i.load(d);
         chk(32'(round_dir), 32'(d[31:30]));
         rd(d & 32'hCF80_0FFF);
      end
   endtask
   task t_accrue;
      iu_model_i.load(32'h0);
      for (int i = 0; i < 3; i++) begin
         iu_model_i.op(1'b0, 1'b0, EX[i], 7'h00);
         chk(32'(fp_exception), 32'h0);
         rd(32'(IMG[i]));
      end
   endtask
   task t_trap;
      iu_model_i.load(32'h0400_0000);
      iu_model_i.op(1'b0, 1'b0, 5'h01, 7'h00);
      chk(32'(fp_exception), 32'h0);
      iu_model_i.op(1'b0, 1'b0, 5'h08, 7'h00);
      chk(32'(fp_exception), 32'h1);
      rd(32'h0400_4028);
      rd(32'h0400_0028);
   endtask
   task t_seq;
      iu_model_i.load(32'h0);
      iu_model_i.op(1'b1, 1'b0, 5'h01, 7'h00);
      chk(32'(fp_exception), 32'h1);
      rd(32'h0001_0000);
      iu_model_i.cmd(1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
      chk(32'(fp_exception), 32'h0);
      iu_model_i.cmd(1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
      chk(32'(fp_exception), 32'h1);
      rd(32'h0001_0000);
   endtask
   task t_cmp;
      iu_model_i.load(32'h0);
      for (int i = 0; i < 5; i++) begin
         iu_model_i.op(1'b0, 1'b1, 5'h00, CV[i]);
         @(posedge clk);
         iu_model_i.cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
         chk(32'(status_data[11:10]), 32'(FC[i]));
         iu_model_i.cmd(1'b0, 1'b0, 1'b0, 1'b1, 4'(FC[i]) + 4'h1);
         chk(32'(branch_taken), 32'h1);
         iu_model_i.cmd(1'b0, 1'b0, 1'b0, 1'b1, 4'h5);
         chk(32'(branch_taken), 32'(FC[i] != 2'h0));
         chk(32'(branch_done), 32'h1);
         iu_model_i.cmd(1'b0, 1'b0, 1'b0, 1'b1, 4'h6);
         chk(32'(branch_taken), 32'(FC[i] != 2'h3));
      end
      iu_model_i.cmd(1'b0, 1'b0, 1'b0, 1'b1, 4'h8);
      chk(32'(branch_taken), 32'h1);
      iu_model_i.cmd(1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
      chk(32'(branch_taken), 32'h0);
      // signalling operand with invalid enabled must trap and keep the code
      iu_model_i.load(32'h0800_0000);
      iu_model_i.op(1'b0, 1'b1, 5'h00, 7'h50);
      @(posedge clk);
      #1;
      chk(32'(fp_exception), 32'h1);
      @(posedge clk);
      iu_model_i.cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
      chk(32'(status_data[11:10]), 32'h0);
   endtask
   task results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rd(32'h0);
      t_round;
      t_accrue;
      t_trap;
      t_seq;
      t_cmp;
      results;
   end
   // the tests take about 140 cycles
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      results;
   end
endmodule
`default_nettype wire
